// ===== include/pcsu_pkg.sv
// constants and types for the program counter and stack unit
// assumes one clock domain; all users write pcsu_pkg::name
package pcsu_pkg;

  localparam int PC_W = 15;
  localparam int PTR_W = 16;
  localparam int DATA_W = 8;
  localparam int PWORD_W = 14;
  localparam int DADDR_W = 12;
  localparam int STACK_DEPTH = 16;
  localparam int PMEM_WORDS = 16384;
  localparam int INSTR_ID_W = 6;
  localparam int CTX_STATUS_W = 5;
  localparam int BSR_W = 5;
  localparam int PCLATH_W = 7;
  localparam int BANK_W = 5;
  localparam int BANK_OFS_W = 7;

  localparam logic [PC_W-1:0] RESET_VEC = 15'h0000;
  localparam logic [PC_W-1:0] INT_VEC = 15'h0004;
  localparam logic [PC_W-1:0] PC_STEP = 15'h0001;

  // bit 7 of the pointer high byte selects program space
  localparam int PROG_SEL_BIT = 15;

  localparam logic [PTR_W-1:0] LIN_BASE = 16'h2000;
  localparam logic [PTR_W-1:0] LIN_LIMIT = 16'h29b0;
  localparam logic [PTR_W-1:0] GPR_BANK_BYTES = 16'h0050;
  localparam logic [BANK_OFS_W-1:0] GPR_OFFSET = 7'h20;

  localparam logic [INSTR_ID_W-1:0] NUM_INSTR = 6'h31;

  typedef enum logic [2:0] {
    OP_NEXT   = 3'h0,
    OP_JUMP   = 3'h1,
    OP_BRANCH = 3'h2,
    OP_CALL   = 3'h3,
    OP_RETURN = 3'h4,
    OP_RETFIE = 3'h5
  } pcsu_op_type;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_DATA  = 4'h2,
    ST_PROG  = 4'h4,
    ST_PROG2 = 4'h8
  } pcsu_ind_state_type;

endpackage

// ===== hw/pcsu_stack.sv
// return address stack, depth and width by parameter
// assumes push and pop never arrive in the same cycle
`timescale 1ns/1ps
module pcsu_stack #(
  parameter int DEPTH = pcsu_pkg::STACK_DEPTH,
  parameter int WIDTH = pcsu_pkg::PC_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] top,
  output logic overflow,
  output logic underflow
);

  localparam int SP_W = $clog2(DEPTH) + 1;
  localparam int IX_W = $clog2(DEPTH);
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(DEPTH);
  localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [SP_W-1:0] sp_ff;
  logic [SP_W-1:0] sp_m1;
  logic full;
  logic empty;

  assign full = (sp_ff == SP_FULL);
  assign empty = (sp_ff == '0);
  assign sp_m1 = sp_ff - SP_ONE;
  assign overflow = push & full;
  assign underflow = pop & empty;
  // empty pop yields zero so a return lands on the reset vector
  assign top = empty ? '0 : mem_ff[sp_m1[IX_W-1:0]];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sp_ff <= '0;
    end else if (clear) begin
      sp_ff <= '0;
    end else if (push && !full) begin
      sp_ff <= sp_ff + SP_ONE;
    end else if (pop && !empty) begin
      sp_ff <= sp_m1;
    end
  end

  // a push on a full stack is dropped, the old entries survive
  always_ff @(posedge clk) begin
    if (push && !full) begin
      mem_ff[sp_ff[IX_W-1:0]] <= din;
    end
  end

endmodule

// ===== hw/pcsu_core.sv
// program counter, return stack, interrupt context and pointers
// assumes all inputs come from logic on clk; memories sit outside
//
// Notes on behaviour
// - sixteen entry stack, fifteen bits each
// - overflow and underflow set sticky flags
// - stack error optionally triggers software reset
// - fifteen bit program counter, 32K word space
// - addresses wrap inside implemented program memory
// - reset starts at zero, interrupt at four
// - interrupt saves context, return from interrupt (OP_RETFIE) restores it
// - two 16-bit pointers reach data and program
// - program space indirect access takes extra cycle
// - linear view of general purpose RAM
// - exactly forty-nine valid instruction codes
// - pointer bit 15 reads program word low byte
// - indirect writes never change program memory
`timescale 1ns/1ps
module pcsu_core #(
  parameter int PMEM_WORDS = pcsu_pkg::PMEM_WORDS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic op_valid,
  input wire pcsu_pkg::pcsu_op_type op_code,
  input wire logic [pcsu_pkg::PC_W-1:0] op_target,
  input wire logic [pcsu_pkg::INSTR_ID_W-1:0] instr_id,
  input wire logic int_req,
  input wire logic stack_reset_en,
  input wire logic clear_overflow,
  input wire logic clear_underflow,
  input wire logic [pcsu_pkg::DATA_W-1:0] ctx_w,
  input wire logic [pcsu_pkg::CTX_STATUS_W-1:0] ctx_status,
  input wire logic [pcsu_pkg::BSR_W-1:0] ctx_bsr,
  input wire logic [pcsu_pkg::PCLATH_W-1:0] ctx_pclath,
  input wire logic ptr_wr_en,
  input wire logic ptr_wr_sel,
  input wire logic [pcsu_pkg::PTR_W-1:0] ptr_wr_data,
  input wire logic ind_req,
  input wire logic ind_sel,
  input wire logic ind_write,
  input wire logic [pcsu_pkg::DATA_W-1:0] ind_wdata,
  input wire logic [pcsu_pkg::DATA_W-1:0] data_rdata,
  input wire logic [pcsu_pkg::PWORD_W-1:0] pmem_rdata,
  output logic [pcsu_pkg::PC_W-1:0] pc,
  output logic stack_overflow_flag,
  output logic stack_underflow_flag,
  output logic soft_reset,
  output logic instr_bad,
  output logic busy,
  output logic ctx_restore,
  output logic [pcsu_pkg::DATA_W-1:0] shadow_w,
  output logic [pcsu_pkg::CTX_STATUS_W-1:0] shadow_status,
  output logic [pcsu_pkg::BSR_W-1:0] shadow_bsr,
  output logic [pcsu_pkg::PCLATH_W-1:0] shadow_pclath,
  output logic [pcsu_pkg::PTR_W-1:0] indirect_pointer0,
  output logic [pcsu_pkg::PTR_W-1:0] indirect_pointer1,
  output logic [pcsu_pkg::DADDR_W-1:0] data_addr,
  output logic data_re,
  output logic data_we,
  output logic [pcsu_pkg::DATA_W-1:0] data_wdata,
  output logic [pcsu_pkg::PC_W-1:0] pmem_addr,
  output logic pmem_re,
  output logic [pcsu_pkg::DATA_W-1:0] ind_rdata,
  output logic ind_done
);

  localparam int PC_W = pcsu_pkg::PC_W;
  localparam int PTR_W = pcsu_pkg::PTR_W;
  localparam logic [PC_W-1:0] PC_MASK = PC_W'(PMEM_WORDS - 1);

  logic [PC_W-1:0] pc_ff;
  logic [PC_W-1:0] nxt_pc;
  logic [PC_W-1:0] pc_inc;
  logic ovf_flag_ff;
  logic unf_flag_ff;
  logic soft_reset_ff;
  logic instr_bad_ff;
  logic busy_ff;
  logic ctx_restore_ff;
  logic [pcsu_pkg::DATA_W-1:0] sh_w_ff;
  logic [pcsu_pkg::CTX_STATUS_W-1:0] sh_status_ff;
  logic [pcsu_pkg::BSR_W-1:0] sh_bsr_ff;
  logic [pcsu_pkg::PCLATH_W-1:0] sh_pclath_ff;
  logic [PTR_W-1:0] sh_ptr0_ff;
  logic [PTR_W-1:0] sh_ptr1_ff;
  logic [PTR_W-1:0] ptr0_ff;
  logic [PTR_W-1:0] ptr1_ff;
  logic [pcsu_pkg::DADDR_W-1:0] data_addr_ff;
  logic data_re_ff;
  logic data_we_ff;
  logic [pcsu_pkg::DATA_W-1:0] data_wdata_ff;
  logic [PC_W-1:0] pmem_addr_ff;
  logic pmem_re_ff;
  logic [pcsu_pkg::DATA_W-1:0] ind_rdata_ff;
  logic ind_done_ff;
  logic ind_rd_ff;
  pcsu_pkg::pcsu_ind_state_type state_ff;
  pcsu_pkg::pcsu_ind_state_type nxt_state;

  logic int_go;
  logic op_go;
  logic is_ret;
  logic push;
  logic pop;
  logic [PC_W-1:0] push_val;
  logic [PC_W-1:0] stk_top;
  logic stk_ovf;
  logic stk_unf;
  logic soft_go;
  logic ind_go;
  logic [PTR_W-1:0] sel_ptr;
  logic sel_prog;

  // linear window maps 80-byte bank slices onto banked GPR
  function automatic logic [pcsu_pkg::DADDR_W-1:0] map_addr(
    input logic [PTR_W-1:0] p
  );
    logic [PTR_W-1:0] off;
    logic [PTR_W-1:0] bank;
    logic [PTR_W-1:0] rem;
    off = p - pcsu_pkg::LIN_BASE;
    bank = off / pcsu_pkg::GPR_BANK_BYTES;
    rem = off - PTR_W'(bank * pcsu_pkg::GPR_BANK_BYTES);
    if (p >= pcsu_pkg::LIN_BASE && p < pcsu_pkg::LIN_LIMIT) begin
      map_addr = {bank[pcsu_pkg::BANK_W-1:0],
                  pcsu_pkg::GPR_OFFSET + rem[pcsu_pkg::BANK_OFS_W-1:0]};
    end else begin
      map_addr = p[pcsu_pkg::DADDR_W-1:0];
    end
  endfunction

  // interrupt wins over the instruction presented in the same cycle
  assign int_go = int_req && !busy_ff;
  assign op_go = op_valid && !busy_ff && !int_req;
  assign is_ret = (op_code == pcsu_pkg::OP_RETURN) ||
                  (op_code == pcsu_pkg::OP_RETFIE);
  assign pc_inc = pc_ff + pcsu_pkg::PC_STEP;
  assign push = int_go || (op_go && op_code == pcsu_pkg::OP_CALL);
  assign pop = op_go && is_ret;
  assign push_val = int_go ? pc_ff : pc_inc;
  assign soft_go = (stk_ovf || stk_unf) && stack_reset_en;
  assign ind_go = ind_req && !busy_ff;
  assign sel_ptr = ind_sel ? ptr1_ff : ptr0_ff;
  assign sel_prog = sel_ptr[pcsu_pkg::PROG_SEL_BIT];

  pcsu_stack #(
    .DEPTH(pcsu_pkg::STACK_DEPTH),
    .WIDTH(PC_W)
  ) u_stack (
    .clk(clk),
    .resetn(resetn),
    .clear(soft_go),
    .push(push),
    .pop(pop),
    .din(push_val),
    .top(stk_top),
    .overflow(stk_ovf),
    .underflow(stk_unf)
  );

  always_comb begin
    nxt_pc = pc_ff;
    if (soft_go) begin
      nxt_pc = pcsu_pkg::RESET_VEC;
    end else if (int_go) begin
      nxt_pc = pcsu_pkg::INT_VEC;
    end else if (op_go) begin
      case (op_code)
        pcsu_pkg::OP_NEXT: nxt_pc = pc_inc;
        pcsu_pkg::OP_JUMP: nxt_pc = op_target;
        pcsu_pkg::OP_BRANCH: nxt_pc = pc_inc + op_target;
        pcsu_pkg::OP_CALL: nxt_pc = op_target;
        pcsu_pkg::OP_RETURN: nxt_pc = stk_top;
        pcsu_pkg::OP_RETFIE: nxt_pc = stk_top;
        default: nxt_pc = pc_inc;
      endcase
    end
  end

  // masking keeps the stored program counter inside the fitted memory; stack entries and pointers are not masked
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_ff <= pcsu_pkg::RESET_VEC;
    end else begin
      pc_ff <= nxt_pc & PC_MASK;
    end
  end

  // a new error beats a software clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ovf_flag_ff <= 1'b0;
      unf_flag_ff <= 1'b0;
      soft_reset_ff <= 1'b0;
    end else begin
      if (stk_ovf) begin
        ovf_flag_ff <= 1'b1;
      end else if (clear_overflow) begin
        ovf_flag_ff <= 1'b0;
      end
      if (stk_unf) begin
        unf_flag_ff <= 1'b1;
      end else if (clear_underflow) begin
        unf_flag_ff <= 1'b0;
      end
      soft_reset_ff <= soft_go;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      instr_bad_ff <= 1'b0;
    end else begin
      instr_bad_ff <= op_go && (instr_id >= pcsu_pkg::NUM_INSTR);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sh_w_ff <= '0;
      sh_status_ff <= '0;
      sh_bsr_ff <= '0;
      sh_pclath_ff <= '0;
      sh_ptr0_ff <= '0;
      sh_ptr1_ff <= '0;
      ctx_restore_ff <= 1'b0;
    end else begin
      if (int_go) begin
        sh_w_ff <= ctx_w;
        sh_status_ff <= ctx_status;
        sh_bsr_ff <= ctx_bsr;
        sh_pclath_ff <= ctx_pclath;
        sh_ptr0_ff <= ptr0_ff;
        sh_ptr1_ff <= ptr1_ff;
      end
      ctx_restore_ff <= op_go && op_code == pcsu_pkg::OP_RETFIE;
    end
  end

  // restore on return beats a pointer write in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ptr0_ff <= '0;
      ptr1_ff <= '0;
    end else if (soft_go) begin
      ptr0_ff <= '0;
      ptr1_ff <= '0;
    end else if (op_go && op_code == pcsu_pkg::OP_RETFIE) begin
      ptr0_ff <= sh_ptr0_ff;
      ptr1_ff <= sh_ptr1_ff;
    end else if (ptr_wr_en) begin
      if (ptr_wr_sel) begin
        ptr1_ff <= ptr_wr_data;
      end else begin
        ptr0_ff <= ptr_wr_data;
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pcsu_pkg::ST_IDLE: begin
        if (ind_go) begin
          nxt_state = sel_prog ? pcsu_pkg::ST_PROG : pcsu_pkg::ST_DATA;
        end
      end
      pcsu_pkg::ST_DATA: nxt_state = pcsu_pkg::ST_IDLE;
      pcsu_pkg::ST_PROG: nxt_state = pcsu_pkg::ST_PROG2;
      pcsu_pkg::ST_PROG2: nxt_state = pcsu_pkg::ST_IDLE;
      default: nxt_state = pcsu_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= pcsu_pkg::ST_IDLE;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= (nxt_state != pcsu_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_addr_ff <= '0;
      data_re_ff <= 1'b0;
      data_we_ff <= 1'b0;
      data_wdata_ff <= '0;
      pmem_addr_ff <= '0;
      pmem_re_ff <= 1'b0;
      ind_rd_ff <= 1'b0;
    end else begin
      data_re_ff <= 1'b0;
      data_we_ff <= 1'b0;
      pmem_re_ff <= 1'b0;
      if (state_ff == pcsu_pkg::ST_IDLE && ind_go) begin
        ind_rd_ff <= !ind_write;
        if (sel_prog) begin
          pmem_addr_ff <= sel_ptr[PC_W-1:0] & PC_MASK;
          pmem_re_ff <= !ind_write;
        end else begin
          data_addr_ff <= map_addr(sel_ptr);
          data_re_ff <= !ind_write;
          data_we_ff <= ind_write;
          data_wdata_ff <= ind_wdata;
        end
      end
    end
  end

  // program words are taken one cycle after the read strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ind_rdata_ff <= '0;
      ind_done_ff <= 1'b0;
    end else begin
      ind_done_ff <= (state_ff == pcsu_pkg::ST_DATA) ||
                     (state_ff == pcsu_pkg::ST_PROG2);
      if (state_ff == pcsu_pkg::ST_DATA && ind_rd_ff) begin
        ind_rdata_ff <= data_rdata;
      end else if (state_ff == pcsu_pkg::ST_PROG2 && ind_rd_ff) begin
        ind_rdata_ff <= pmem_rdata[pcsu_pkg::DATA_W-1:0];
      end
    end
  end

  assign pc = pc_ff;
  assign stack_overflow_flag = ovf_flag_ff;
  assign stack_underflow_flag = unf_flag_ff;
  assign soft_reset = soft_reset_ff;
  assign instr_bad = instr_bad_ff;
  assign busy = busy_ff;
  assign ctx_restore = ctx_restore_ff;
  assign shadow_w = sh_w_ff;
  assign shadow_status = sh_status_ff;
  assign shadow_bsr = sh_bsr_ff;
  assign shadow_pclath = sh_pclath_ff;
  assign indirect_pointer0 = ptr0_ff;
  assign indirect_pointer1 = ptr1_ff;
  assign data_addr = data_addr_ff;
  assign data_re = data_re_ff;
  assign data_we = data_we_ff;
  assign data_wdata = data_wdata_ff;
  assign pmem_addr = pmem_addr_ff;
  assign pmem_re = pmem_re_ff;
  assign ind_rdata = ind_rdata_ff;
  assign ind_done = ind_done_ff;

endmodule

// ===== verification/pcsu_core_assertions.sv
// checker for pcsu_core program flow and indirect access
// assumes it is bound into pcsu_core; one clock, active low reset
`timescale 1ns/1ps
module pcsu_chk #(
  parameter int PMEM_WORDS = 16384
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic op_valid,
  input wire pcsu_pkg::pcsu_op_type op_code,
  input wire logic [14:0] op_target,
  input wire logic [5:0] instr_id,
  input wire logic int_req,
  input wire logic [7:0] ctx_w,
  input wire logic ind_req,
  input wire logic ind_sel,
  input wire logic ind_write,
  input wire logic [14:0] pc,
  input wire logic soft_reset,
  input wire logic instr_bad,
  input wire logic busy,
  input wire logic [7:0] shadow_w,
  input wire logic [15:0] indirect_pointer0,
  input wire logic [15:0] indirect_pointer1,
  input wire logic data_we,
  input wire logic data_re,
  input wire logic pmem_re,
  input wire logic [14:0] pmem_addr,
  input wire logic ind_done
);
  localparam logic [14:0] MASK = 15'(PMEM_WORDS - 1);
  logic acc, go, pg, bad;
  logic [15:0] sp;
  logic [14:0] pa;
  assign acc = op_valid && !busy && !int_req;
  assign go = ind_req && !busy;
  assign sp = ind_sel ? indirect_pointer1 : indirect_pointer0;
  assign pg = go && sp[15];
  assign pa = sp[14:0] & MASK;
  assign bad = acc && instr_id >= pcsu_pkg::NUM_INSTR;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence prog_walk;
    busy ##1 busy ##1 !busy && ind_done;
  endsequence
  sequence data_walk;
    busy ##1 !busy && ind_done;
  endsequence
  a_pc_in_space: assert property (pc == (pc & MASK))
    else $error("pc outside space");
  a_int_vector: assert property (
    int_req && !busy |=> pc == pcsu_pkg::INT_VEC || soft_reset)
    else $error("no interrupt vector");
  a_int_shadow: assert property (
    int_req && !busy |=> shadow_w == $past(ctx_w) || soft_reset)
    else $error("context not saved");
  a_call_target: assert property (
    acc && op_code == pcsu_pkg::OP_CALL
    |=> pc == ($past(op_target) & MASK) || soft_reset)
    else $error("call target wrong");
  a_prog_extra: assert property (pg |=> prog_walk)
    else $error("program access timing");
  a_data_walk: assert property (go && !sp[15] |=> data_walk)
    else $error("data access timing");
  a_prog_addr: assert property (
    pg && !ind_write |=> pmem_re && pmem_addr == $past(pa))
    else $error("program fetch address");
  a_no_prog_wr: assert property (
    pg && ind_write |=> (!data_we && !data_re && !pmem_re) [*3])
    else $error("strobe on program write");
  a_bad_code: assert property (1'b1 |=> instr_bad == $past(bad))
    else $error("bad code pulse");
endmodule

bind pcsu_core pcsu_chk #(.PMEM_WORDS(PMEM_WORDS)) pcsu_chk_inst (
  .clk, .resetn, .op_valid, .op_code, .op_target, .instr_id, .int_req,
  .ctx_w, .ind_req, .ind_sel, .ind_write, .pc, .soft_reset, .instr_bad,
  .busy, .shadow_w, .indirect_pointer0, .indirect_pointer1, .data_we,
  .data_re, .pmem_re, .pmem_addr, .ind_done
);

// ===== verification/tb_top.sv
// self-checking bench for pcsu_core against a queue model
// assumes the checker is bound in; memories are played by the bench
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, resetn = 1'b0, op_valid = 1'b0, int_req = 1'b0;
  logic stack_reset_en = 1'b0, clear_overflow = 1'b0;
  logic clear_underflow = 1'b0, ptr_wr_en = 1'b0, ptr_wr_sel = 1'b0;
  logic ind_req = 1'b0, ind_sel = 1'b0, ind_write = 1'b0;
  pcsu_pkg::pcsu_op_type op_code = pcsu_pkg::OP_NEXT;
  logic [14:0] op_target = 15'h0000;
  logic [5:0] instr_id = 6'h00;
  logic [7:0] ctx_w = 8'h00, ind_wdata = 8'h00, data_rdata = 8'h00;
  logic [4:0] ctx_status = 5'h00, ctx_bsr = 5'h00;
  logic [6:0] ctx_pclath = 7'h00;
  logic [15:0] ptr_wr_data = 16'h0000;
  logic [13:0] pmem_rdata = 14'h0000;
  logic [14:0] pc, pmem_addr;
  logic stack_overflow_flag, stack_underflow_flag, soft_reset, instr_bad;
  logic busy, ctx_restore, data_re, data_we, pmem_re, ind_done;
  logic [7:0] shadow_w, data_wdata, ind_rdata;
  logic [4:0] shadow_status, shadow_bsr;
  logic [6:0] shadow_pclath;
  logic [15:0] indirect_pointer0, indirect_pointer1;
  logic [11:0] data_addr;
  int failures = 0, checks_done = 0, mpc = 0, i;
  int stk[$];
  logic [15:0] mptr [2] = '{16'h0000, 16'h0000};
  logic [15:0] sptr [2] = '{16'h0000, 16'h0000};
  logic [7:0] msw = 8'h00, mrd = 8'h00;
  logic [16:0] msh = 17'h00000;
  logic ovf_e = 1'b0, unf_e = 1'b0;
  logic [31:0] rnd = 32'd82108;

  pcsu_core pcsu_core_inst (
    .clk, .resetn, .op_valid, .op_code, .op_target, .instr_id, .int_req,
    .stack_reset_en, .clear_overflow, .clear_underflow, .ctx_w,
    .ctx_status, .ctx_bsr, .ctx_pclath, .ptr_wr_en, .ptr_wr_sel,
    .ptr_wr_data, .ind_req, .ind_sel, .ind_write, .ind_wdata, .data_rdata,
    .pmem_rdata, .pc, .stack_overflow_flag, .stack_underflow_flag,
    .soft_reset, .instr_bad, .busy, .ctx_restore, .shadow_w, .shadow_status,
    .shadow_bsr, .shadow_pclath, .indirect_pointer0, .indirect_pointer1,
    .data_addr, .data_re, .data_we, .data_wdata, .pmem_addr, .pmem_re,
    .ind_rdata, .ind_done
  );

  always #4 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // a full stack drops the entry, so the model keeps at most 16
  task automatic mpush(input int v, inout logic err);
    if (stk.size() == 16) begin
      ovf_e = 1'b1;
      err = 1'b1;
    end else stk.push_back(v);
  endtask

  task automatic settle(input logic err, rst, bad);
    mpc = mpc & (pcsu_pkg::PMEM_WORDS - 1);
    if (err && stack_reset_en) begin
      mpc = 0;
      stk.delete();
      mptr = '{16'h0000, 16'h0000};
    end
    #1;
    check("pc", pc, mpc);
    check("ovf", stack_overflow_flag, ovf_e);
    check("unf", stack_underflow_flag, unf_e);
    check("soft_reset", soft_reset, err && stack_reset_en);
    check("instr_bad", instr_bad, bad);
    check("ctx_restore", ctx_restore, rst);
    check("shadow_w", shadow_w, msw);
    check("shadow_sb", {shadow_status, shadow_bsr}, msh[16:7]);
    check("shadow_pclath", shadow_pclath, msh[6:0]);
    check("ptr0", indirect_pointer0, mptr[0]);
    check("ptr1", indirect_pointer1, mptr[1]);
  endtask

  task automatic do_op(input pcsu_pkg::pcsu_op_type k, input int t, id);
    logic err;
    err = 1'b0;
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= k;
    op_target <= 15'(t);
    instr_id <= 6'(id);
    @(posedge clk);
    op_valid <= 1'b0;
    case (k)
      pcsu_pkg::OP_NEXT: mpc = mpc + 1;
      pcsu_pkg::OP_JUMP: mpc = t;
      pcsu_pkg::OP_BRANCH: mpc = mpc + 1 + t;
      pcsu_pkg::OP_CALL: begin
        mpush(mpc + 1, err);
        mpc = t;
      end
      default: begin
        if (stk.size() == 0) begin
          unf_e = 1'b1;
          err = 1'b1;
          mpc = 0;
        end else mpc = stk.pop_back();
        if (k == pcsu_pkg::OP_RETFIE) mptr = sptr;
      end
    endcase
    settle(err, k == pcsu_pkg::OP_RETFIE, id >= 49);
  endtask

  task automatic do_int();
    logic err;
    err = 1'b0;
    rnd = lfsr(rnd);
    @(posedge clk);
    int_req <= 1'b1;
    ctx_w <= rnd[7:0];
    {ctx_status, ctx_bsr, ctx_pclath} <= rnd[24:8];
    @(posedge clk);
    int_req <= 1'b0;
    mpush(mpc, err);
    mpc = 4;
    sptr = mptr;
    msw = rnd[7:0];
    msh = rnd[24:8];
    settle(err, 1'b0, 1'b0);
  endtask

  task automatic wr_ptr(input int s, input logic [15:0] v);
    @(posedge clk);
    ptr_wr_en <= 1'b1;
    ptr_wr_sel <= s[0];
    ptr_wr_data <= v;
    @(posedge clk);
    ptr_wr_en <= 1'b0;
    mptr[s] = v;
    settle(1'b0, 1'b0, 1'b0);
  endtask

  // bus values are inverted outside their valid cycle
  task automatic do_ind(input int s, wr);
    logic [15:0] p;
    logic [13:0] w;
    logic [7:0] d;
    logic [11:0] a;
    int off;
    p = mptr[s];
    rnd = lfsr(rnd);
    d = rnd[7:0];
    w = rnd[21:8];
    off = p - 16'h2000;
    a = p[11:0];
    if (p >= 16'h2000 && p < 16'h29b0) a = {5'(off / 80), 7'(32 + off % 80)};
    @(posedge clk);
    ind_req <= 1'b1;
    ind_sel <= s[0];
    ind_write <= wr[0];
    ind_wdata <= d;
    @(posedge clk);
    ind_req <= 1'b0;
    data_rdata <= d;
    pmem_rdata <= ~w;
    #1;
    check("data_we", data_we, wr && !p[15]);
    check("data_re", data_re, !wr && !p[15]);
    check("pmem_re", pmem_re, !wr && p[15]);
    if (!p[15]) check("data_addr", data_addr, a);
    if (!p[15] && wr) check("wdata", data_wdata, d);
    if (p[15] && !wr) check("pmem_addr", pmem_addr, p[13:0]);
    @(posedge clk);
    data_rdata <= ~d;
    pmem_rdata <= w;
    #1;
    check("busy", busy, p[15]);
    if (p[15]) begin
      @(posedge clk);
      pmem_rdata <= ~w;
      #1;
    end
    check("ind_done", ind_done, 1'b1);
    if (!wr) mrd = p[15] ? w[7:0] : d;
    check("ind_rdata", ind_rdata, mrd);
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    settle(1'b0, 1'b0, 1'b0);
    do_op(pcsu_pkg::OP_JUMP, 32'h7ffe, 3);
    do_op(pcsu_pkg::OP_NEXT, 0, 48);
    do_op(pcsu_pkg::OP_NEXT, 0, 49);
    do_op(pcsu_pkg::OP_BRANCH, 5, 63);
    do_int();
    do_op(pcsu_pkg::OP_CALL, rnd[12:0], 0);
    do_op(pcsu_pkg::OP_RETURN, 0, 1);
    do_op(pcsu_pkg::OP_RETFIE, 0, 2);
    wr_ptr(0, 16'h2055);
    wr_ptr(1, 16'h8123);
    do_int();
    wr_ptr(0, 16'h0123);
    for (i = 0; i < 4; i++) do_ind(i / 2, i % 2);
    do_op(pcsu_pkg::OP_RETFIE, 0, 0);
    do_ind(0, 0);
    do_ind(0, 1);
    for (i = 0; i < 17; i++) do_op(pcsu_pkg::OP_CALL, lfsr(rnd + i), 0);
    for (i = 0; i < 17; i++) do_op(pcsu_pkg::OP_RETURN, 0, 0);
    @(posedge clk);
    {clear_overflow, clear_underflow} <= 2'b11;
    @(posedge clk);
    {clear_overflow, clear_underflow} <= 2'b00;
    {ovf_e, unf_e} = 2'b00;
    stack_reset_en <= 1'b1;
    settle(1'b0, 1'b0, 1'b0);
    for (i = 0; i < 17; i++) do_op(pcsu_pkg::OP_CALL, i * 9, 0);
    do_op(pcsu_pkg::OP_RETURN, 0, 0);
    // mid-run reset must clear flags, shadows and the stack
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    stack_reset_en <= 1'b0;
    mpc = 0;
    stk.delete();
    mptr = '{16'h0000, 16'h0000};
    sptr = mptr;
    {msw, msh, mrd, ovf_e, unf_e} = '0;
    settle(1'b0, 1'b0, 1'b0);
    do_op(pcsu_pkg::OP_CALL, 15'h0321, 0);
    do_op(pcsu_pkg::OP_RETURN, 0, 0);
    end_of_test();
  end
endmodule
